//--- asc_pkg.sv
/*
  Shared constants for the converter sequence control block: register
  offsets, reset values, sequencer timing and state codes.
  Assumes the die-to-die bus presents an offset inside a 0x02xx or 0x03xx page.
*/
// Summary of operation
// [R1] Config bit 7 enables the sequence-complete interrupt request.
// [R2] Config bit 6 turns continuous conversion on; clear means single pass.
// [R3] Config bit 5 enables offset compensation; software also selects channel 15.
// [R4] Config bit 4 holds converter logic at initial values until cleared.
// [R5] Config bits 2:0 pick bus-to-converter clock divide: 10,8,6,4,2,1,1,1.
// [R6] Software should hold soft reset while changing the bus clock rate.
// [R7] Status offset 0x81 bit 7 is sequence done; any status read clears it.
// [R8] Status bit 6 shows reference current limit; bits 5 and 4 read zero.
// [R9] Status bits 3:0 show channel converting now; reset value all ones.
// [R10] Channels are visited in order 15, then 0 upward through 14.
// [R11] Each channel-select bit adds that channel to the sequence.
// [R12] A high-byte or word channel-select write aborts any running sequence and starts anew.
// [R13] Writing zero to channel select stops and idles the converter.
// [R14] Any channel-select write clears every per-channel done flag.
// [R15] Only a high-byte or word write to channel select starts conversion.
// [R16] Done flags at 0x84/0x85 set on completion; bit 13 zero; reset zero.
// [R17] Byte reads of done flags return live status, nothing latched.
// [R18] Each channel has a 16-bit left-adjusted result register.
// [R19] Reading a channel result clears that channel's done flag.
// [R20] Result low-byte read latches high byte; high-byte read clears flag.
// [R21] Channels 0-8 external, 9-12 sense inputs, 13 absent, 14 bandgap, 15 cal.
// [R22] Offsets decode in page 0x0200 blocking and 0x0300 non-blocking.
// [R23] Result high byte holds bits 9:2, low byte top bits hold bits 1:0.
// [R24] Conversion: 9 sample ticks, 18 convert ticks, 4 ticks between channels.
// [R25] Last channel done sets done flag and request; continuous mode restarts.
// [R26] Writes to read-only registers do nothing; unused channel bits read zero.
package asc_pkg;

  // Address pages and register offsets (big-endian pairs: even byte is high)
  localparam logic [7:0] PAGE_BLOCKING    = 8'h02;
  localparam logic [7:0] PAGE_NONBLOCKING = 8'h03;
  localparam logic [7:0] OFF_CONFIG       = 8'h80;
  localparam logic [7:0] OFF_STATUS       = 8'h81;
  localparam logic [7:0] OFF_SELECT       = 8'h82;
  localparam logic [7:0] OFF_DONE         = 8'h84;
  localparam logic [7:0] OFF_RESULT_FIRST = 8'h86;
  localparam logic [7:0] OFF_RESULT_LAST  = 8'hA5;

  // Field positions
  localparam int CFG_IRQ_EN_BIT   = 7;
  localparam int CFG_CONT_BIT     = 6;
  localparam int CFG_OFFSET_BIT   = 5;
  localparam int CFG_SOFT_RST_BIT = 4;
  localparam int ABSENT_CHANNEL   = 13;

  // Reset values
  localparam logic [7:0]  CONFIG_RESET  = 8'h00;
  localparam logic [3:0]  COUNTER_RESET = 4'hF;
  localparam logic [15:0] SELECT_RESET  = 16'h0000;
  localparam logic [15:0] DONE_RESET    = 16'h0000;
  localparam logic [15:0] IMPL_MASK     = 16'hDFFF;
  localparam logic [3:0]  FIRST_CHANNEL = 4'hF;

  // Sequencer timing in converter-clock ticks
  localparam logic [4:0] SAMPLE_TICKS  = 5'd9;
  localparam logic [4:0] CONVERT_TICKS = 5'd18;
  localparam logic [4:0] GAP_TICKS     = 5'd4;

  typedef enum logic [4:0] {
    ASC_IDLE    = 5'b00001,
    ASC_SEEK    = 5'b00010,
    ASC_SAMPLE  = 5'b00100,
    ASC_CONVERT = 5'b01000,
    ASC_GAP     = 5'b10000
  } asc_state_t;

endpackage

//--- asc_sequence_control.sv
/*
  Converter sequence control: configuration, status, channel select,
  per-channel done flags and result registers, prescaler and sequencer.
  Assumes a synchronous byte/word die-to-die register port and an analog
  converter that presents its 10-bit result when the convert phase ends.
*/
`timescale 1ns/1ns
module asc_sequence_control (
  // Clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_b,
  // Die-to-die register port
  input  wire logic [15:0] i_bus_addr,
  input  wire logic        i_bus_rd,
  input  wire logic        i_bus_wr,
  input  wire logic        i_bus_word,
  input  wire logic [15:0] i_bus_wdata,
  output logic      [15:0] o_bus_rdata,
  output logic             o_bus_ack,
  // Analog converter side
  input  wire logic [9:0]  i_conv_result,
  input  wire logic        i_ref_current_limit,
  output logic             o_converter_clock,
  output logic      [3:0]  o_conv_channel,
  output logic             o_conv_sample,
  output logic             o_conv_convert,
  output logic             o_offset_comp_en,
  output logic             o_converter_soft_reset,
  // Interrupt request
  output logic             o_seq_done_irq
);

  asc_pkg::asc_state_t state;
  logic [7:0]  converter_config;
  logic [15:0] channel_select;
  logic [15:0] channel_done_flags;
  logic [9:0]  result_mem [16];
  logic [3:0]  channel_counter;
  logic [4:0]  phase_cnt;
  logic [3:0]  div_cnt;
  logic        seq_done_flag;
  logic        ref_current_limit_flag;
  logic [7:0]  hi_latch;
  logic        latch_valid;
  logic [3:0]  latch_ch;

  // Next channel after cur in visiting order 15,0,1..14; bit 4 set when found
  function automatic logic [4:0] next_selected(input logic [15:0] sel,
                                               input logic [3:0]  cur);
    logic [4:0] res;
    logic [3:0] cand;
    res = 5'd0;
    for (int i = 15; i >= 1; i--) begin
      cand = cur + 4'(i);
      if (sel[cand] && ((cand + 4'd1) > (cur + 4'd1))) begin
        res = {1'b1, cand};
      end
    end
    return res;
  endfunction

  // Address decode
  wire        page_ok  = (i_bus_addr[15:8] == asc_pkg::PAGE_BLOCKING) ||
                         (i_bus_addr[15:8] == asc_pkg::PAGE_NONBLOCKING);             // R22
  wire [7:0]  off      = i_bus_addr[7:0];
  wire [7:0]  off_even = {off[7:1], 1'b0};
  wire        hit      = page_ok && (off >= asc_pkg::OFF_CONFIG) &&
                         (off <= asc_pkg::OFF_RESULT_LAST);
  wire        wr_hi    = i_bus_wr && hit && (i_bus_word || !off[0]);
  wire        wr_lo    = i_bus_wr && hit && (i_bus_word || off[0]);
  wire        rd_hi    = i_bus_rd && hit && (i_bus_word || !off[0]);
  wire        rd_lo    = i_bus_rd && hit && (i_bus_word || off[0]);
  wire [7:0]  wd_hi    = i_bus_word ? i_bus_wdata[15:8] : i_bus_wdata[7:0];
  wire [7:0]  wd_lo    = i_bus_wdata[7:0];
  wire        at_cfg   = (off_even == asc_pkg::OFF_CONFIG);
  wire        at_sel   = (off_even == asc_pkg::OFF_SELECT);
  wire        at_done  = (off_even == asc_pkg::OFF_DONE);
  wire        at_res   = (off_even >= asc_pkg::OFF_RESULT_FIRST);
  wire [7:0]  res_rel  = off_even - asc_pkg::OFF_RESULT_FIRST;
  wire [3:0]  res_ch   = res_rel[4:1];

  // Config, status read and channel-select write strobes
  wire        soft_rst   = converter_config[asc_pkg::CFG_SOFT_RST_BIT];
  wire        cfg_wr     = wr_hi && at_cfg;
  wire        status_rd  = rd_lo && at_cfg;                                           // R7
  wire        sel_wr_hi  = wr_hi && at_sel && !soft_rst;
  wire        sel_wr_lo  = wr_lo && at_sel && !soft_rst;
  wire        sel_wr     = sel_wr_hi || sel_wr_lo;
  wire [15:0] next_sel   = {sel_wr_hi ? wd_hi : channel_select[15:8],
                            sel_wr_lo ? wd_lo : channel_select[7:0]}
                           & asc_pkg::IMPL_MASK;                                      // R26
  wire        res_rd_hi  = rd_hi && at_res;
  wire        res_rd_lo  = rd_lo && at_res && !i_bus_word;
  wire        res_use_latch = !i_bus_word && latch_valid && (latch_ch == res_ch);

  // Prescaler: one-cycle converter tick every divide bus cycles
  logic [3:0] divide;
  always_comb begin
    case (converter_config[2:0])                                                      // R5
      3'b000:  divide = 4'd10;
      3'b001:  divide = 4'd8;
      3'b010:  divide = 4'd6;
      3'b011:  divide = 4'd4;
      3'b100:  divide = 4'd2;
      default: divide = 4'd1;
    endcase
  end
  wire        tick = (div_cnt >= divide - 4'd1);

  // Sequencer events
  wire        in_seek    = (state == asc_pkg::ASC_SEEK);
  wire        in_sample  = (state == asc_pkg::ASC_SAMPLE);
  wire        in_convert = (state == asc_pkg::ASC_CONVERT);
  wire        in_gap     = (state == asc_pkg::ASC_GAP);
  wire        sample_end = in_sample && tick && (phase_cnt == asc_pkg::SAMPLE_TICKS - 5'd1);
  wire        conv_end   = in_convert && tick &&
                           (phase_cnt == asc_pkg::CONVERT_TICKS - 5'd1);              // R24
  wire        gap_end    = in_gap && tick && (phase_cnt == asc_pkg::GAP_TICKS - 5'd1);
  wire [4:0]  upcoming   = next_selected(channel_select, channel_counter);            // R10
  wire        seq_end    = conv_end && !upcoming[4];
  wire        restart    = seq_end && converter_config[asc_pkg::CFG_CONT_BIT];        // R2
  wire        counting   = in_sample || in_convert || in_gap;

  asc_pkg::asc_state_t next_state;
  logic [3:0]          next_counter;
  always_comb begin
    next_state   = state;
    next_counter = channel_counter;
    if (sel_wr_hi) begin                                                              // R12
      next_state   = (next_sel == 16'h0000) ? asc_pkg::ASC_IDLE : asc_pkg::ASC_SEEK; // R13
      next_counter = asc_pkg::FIRST_CHANNEL;                                          // R15
    end else if (sel_wr_lo && next_sel == 16'h0000) begin
      next_state = asc_pkg::ASC_IDLE;                                                 // R13
    end else if (tick) begin
      case (state)
        asc_pkg::ASC_SEEK: begin
          if (channel_select[channel_counter]) begin                                  // R11
            next_state = asc_pkg::ASC_SAMPLE;
          end else begin
            next_counter = channel_counter + 4'd1;
          end
        end
        asc_pkg::ASC_SAMPLE: begin
          if (sample_end) begin
            next_state = asc_pkg::ASC_CONVERT;
          end
        end
        asc_pkg::ASC_CONVERT: begin
          if (conv_end && upcoming[4]) begin
            next_state   = asc_pkg::ASC_GAP;
            next_counter = upcoming[3:0];
          end else if (restart) begin                                                 // R25
            next_state   = asc_pkg::ASC_SEEK;
            next_counter = asc_pkg::FIRST_CHANNEL;
          end else if (seq_end) begin
            next_state = asc_pkg::ASC_IDLE;
          end
        end
        asc_pkg::ASC_GAP: begin
          if (gap_end) begin
            next_state = asc_pkg::ASC_SAMPLE;
          end
        end
        default: next_state = state;
      endcase
    end
  end

  // Done flags: completion set wins over a select-write or result-read clear in the same cycle
  wire [15:0] set_mask = conv_end ? ((16'h0001 << channel_counter) & asc_pkg::IMPL_MASK)
                                  : 16'h0000;                                         // R16
  wire [15:0] clr_mask = sel_wr ? 16'hFFFF :                                          // R14
                         (res_rd_hi ? (16'h0001 << res_ch) : 16'h0000);               // R19
  wire [15:0] next_flags = (channel_done_flags & ~clr_mask) | set_mask;

  // Read data
  wire [9:0]  res_word = result_mem[res_ch];
  logic [7:0] rd_hi_byte;
  logic [7:0] rd_lo_byte;
  always_comb begin
    if (at_cfg) begin
      rd_hi_byte = {converter_config[7:4], 1'b0, converter_config[2:0]};
      rd_lo_byte = {seq_done_flag, ref_current_limit_flag, 2'b00, channel_counter};   // R8 R9
    end else if (at_sel) begin
      rd_hi_byte = channel_select[15:8];
      rd_lo_byte = channel_select[7:0];
    end else if (at_done) begin
      rd_hi_byte = channel_done_flags[15:8];                                          // R17
      rd_lo_byte = channel_done_flags[7:0];
    end else if (at_res) begin
      rd_hi_byte = res_use_latch ? hi_latch : res_word[9:2];                          // R20 R23
      rd_lo_byte = {res_word[1:0], 6'b00_0000};                                       // R18
    end else begin
      rd_hi_byte = 8'h00;
      rd_lo_byte = 8'h00;
    end
  end
  wire [15:0] next_rdata = i_bus_word ? {rd_hi_byte, rd_lo_byte} :
                           {8'h00, off[0] ? rd_lo_byte : rd_hi_byte};

  // Register port answer
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_bus_rdata <= 16'h0000;
      o_bus_ack   <= 1'b0;
    end else begin
      o_bus_ack <= (i_bus_rd || i_bus_wr) && hit;
      if (i_bus_rd && hit) begin
        o_bus_rdata <= next_rdata;
      end
    end
  end

  // Configuration survives the soft reset it controls
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      converter_config <= asc_pkg::CONFIG_RESET;
    end else if (cfg_wr) begin
      converter_config <= wd_hi;                                                      // R26
    end
  end

  // Converter logic, held at initial values by the soft reset
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state                  <= asc_pkg::ASC_IDLE;
      channel_counter        <= asc_pkg::COUNTER_RESET;
      channel_select         <= asc_pkg::SELECT_RESET;
      channel_done_flags     <= asc_pkg::DONE_RESET;
      seq_done_flag          <= 1'b0;
      ref_current_limit_flag <= 1'b0;
      phase_cnt              <= 5'd0;
      div_cnt                <= 4'd0;
    end else if (soft_rst) begin                                                      // R4
      state                  <= asc_pkg::ASC_IDLE;
      channel_counter        <= asc_pkg::COUNTER_RESET;
      channel_select         <= asc_pkg::SELECT_RESET;
      channel_done_flags     <= asc_pkg::DONE_RESET;
      seq_done_flag          <= 1'b0;
      ref_current_limit_flag <= 1'b0;
      phase_cnt              <= 5'd0;
      div_cnt                <= 4'd0;
    end else begin
      state                  <= next_state;
      channel_counter        <= next_counter;
      channel_done_flags     <= next_flags;
      ref_current_limit_flag <= i_ref_current_limit;                                  // R8
      div_cnt                <= tick ? 4'd0 : div_cnt + 4'd1;
      if (sel_wr) begin
        channel_select <= next_sel;
      end
      if (seq_end) begin
        seq_done_flag <= 1'b1;                                                        // R25
      end else if (status_rd) begin
        seq_done_flag <= 1'b0;                                                        // R7
      end
      if (sel_wr_hi || next_state != state || !counting) begin
        phase_cnt <= 5'd0;
      end else if (tick) begin
        phase_cnt <= phase_cnt + 5'd1;
      end
    end
  end

  // Result storage, one word per channel
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      for (int c = 0; c < 16; c++) begin
        result_mem[c] <= 10'd0;
      end
    end else if (soft_rst) begin
      for (int c = 0; c < 16; c++) begin
        result_mem[c] <= 10'd0;
      end
    end else if (conv_end && channel_counter != 4'(asc_pkg::ABSENT_CHANNEL)) begin   // R21
      result_mem[channel_counter] <= i_conv_result;                                   // R18
    end
  end

  // Byte-read latch keeps a result's high half coherent with its low half
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      hi_latch    <= 8'h00;
      latch_valid <= 1'b0;
      latch_ch    <= 4'h0;
    end else if (soft_rst) begin
      latch_valid <= 1'b0;
    end else if (res_rd_lo) begin
      hi_latch    <= res_word[9:2];                                                   // R20
      latch_valid <= 1'b1;
      latch_ch    <= res_ch;
    end else if (res_rd_hi) begin
      latch_valid <= 1'b0;
    end
  end

  // Converter-facing outputs
  assign o_converter_clock      = tick && !soft_rst;
  assign o_conv_channel         = channel_counter;
  assign o_conv_sample          = in_sample;
  assign o_conv_convert         = in_convert;
  assign o_offset_comp_en       = converter_config[asc_pkg::CFG_OFFSET_BIT];          // R3
  assign o_converter_soft_reset = soft_rst;
  assign o_seq_done_irq         = seq_done_flag &&
                                  converter_config[asc_pkg::CFG_IRQ_EN_BIT];          // R1

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);

  status_clear_a: assert property (status_rd && !seq_end && !soft_rst |=> !seq_done_flag) // R7
    else $error("status read left sequence done flag set");
  // A soft reset landing on the last tick wipes the flag, so it is left out here
  irq_gate_a: assert property (seq_end && converter_config[asc_pkg::CFG_IRQ_EN_BIT]
                               && !cfg_wr && !soft_rst |=> o_seq_done_irq)            // R1
    else $error("enabled sequence end gave no interrupt request");
  soft_hold_a: assert property (soft_rst |=> state == asc_pkg::ASC_IDLE
                                && channel_done_flags == 16'h0000 && channel_counter == 4'hF) // R4
    else $error("soft reset did not hold converter logic");
  // A completion in the same cycle as the write still sets its own flag
  sel_clear_a: assert property (sel_wr && !soft_rst && !conv_end
                                |=> channel_done_flags == 16'h0000)                   // R14
    else $error("channel select write kept done flags");
  start_order_a: assert property (sel_wr_hi && next_sel != 16'h0000
                                  |=> in_seek && channel_counter == 4'hF)             // R12
    else $error("high byte write did not start at first channel");
  low_no_start_a: assert property (sel_wr_lo && !sel_wr_hi && state == asc_pkg::ASC_IDLE
                                   |=> state == asc_pkg::ASC_IDLE)                    // R15
    else $error("low byte write started a conversion");
  zero_stop_a: assert property (sel_wr_hi && next_sel == 16'h0000 |=> state == asc_pkg::ASC_IDLE) // R13
    else $error("zero select did not stop conversion");
  sample_len_a: assert property ($rose(in_convert) |-> $past(phase_cnt) == 5'd8) // R24
    else $error("sample phase length wrong");
  absent_zero_a: assert property (!channel_done_flags[13] && !channel_select[13]) // R16
    else $error("absent channel bit set");
  status_rsv_a: assert property (i_bus_rd && hit && off == asc_pkg::OFF_STATUS && !i_bus_word
                                 |=> o_bus_rdata[5:4] == 2'b00 && o_bus_ack)          // R8
    else $error("status reserved bits not zero");
  result_clear_a: assert property (res_rd_hi && !conv_end && !soft_rst
                                   |=> !channel_done_flags[$past(res_ch)])            // R19
    else $error("result read kept its done flag");

endmodule // asc_sequence_control

//--- asc_analog_model.sv
/*
  Stand-in for the analog converter behind the sequence control block.
  Assumes the sequencer holds channel and convert level steady for the phase.
*/
`timescale 1ns/1ns
module asc_analog_model (
  // Clock
  input  wire logic       i_core_clk,
  // Sequencer side
  input  wire logic [3:0] i_channel,
  input  wire logic       i_convert,
  output logic      [9:0] o_result
);
  // Outside the convert phase the value flips every cycle, so a stale sample shows up
  initial o_result = 10'h000;
  always @(posedge i_core_clk) begin
    if (i_convert) begin
      o_result <= {i_channel, ~i_channel, 2'b10};
    end else begin
      o_result <= ~o_result;
    end
  end
endmodule // asc_analog_model

//--- asc_sequence_control_tb.sv
/*
  Self-checking bench for the converter sequence control block.
  Assumes the one-cycle read/write strobes and one-cycle ack of the register port.
*/
`timescale 1ns/1ns
`define CHK(nm, ex, gt) begin compares++; if ((gt) !== (ex)) begin mismatches++; \
  $display("[ERR] %s expected %h seen %h", nm, ex, gt); end end
module asc_sequence_control_tb;
  logic        i_core_clk = 1'b0;
  logic        i_rst_b = 1'b0;
  logic [15:0] i_bus_addr = 16'h0000;
  logic        i_bus_rd = 1'b0;
  logic        i_bus_wr = 1'b0;
  logic        i_bus_word = 1'b0;
  logic [15:0] i_bus_wdata = 16'h0000;
  logic        i_ref_current_limit = 1'b0;
  logic [15:0] o_bus_rdata;
  logic        o_bus_ack;
  logic [9:0]  conv_result;
  logic        o_converter_clock;
  logic [3:0]  o_conv_channel;
  logic        o_conv_sample;
  logic        o_conv_convert;
  logic        o_offset_comp_en;
  logic        o_converter_soft_reset;
  logic        o_seq_done_irq;
  logic        prev_sample = 1'b0;
  logic [3:0]  order[$];
  int          mismatches = 0;
  int          compares = 0;
  int          n;
  logic [15:0] q;
  logic        k;

  asc_sequence_control dut (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
    .i_bus_addr(i_bus_addr), .i_bus_rd(i_bus_rd), .i_bus_wr(i_bus_wr),
    .i_bus_word(i_bus_word), .i_bus_wdata(i_bus_wdata), .o_bus_rdata(o_bus_rdata),
    .o_bus_ack(o_bus_ack), .i_conv_result(conv_result),
    .i_ref_current_limit(i_ref_current_limit), .o_converter_clock(o_converter_clock),
    .o_conv_channel(o_conv_channel), .o_conv_sample(o_conv_sample),
    .o_conv_convert(o_conv_convert), .o_offset_comp_en(o_offset_comp_en),
    .o_converter_soft_reset(o_converter_soft_reset), .o_seq_done_irq(o_seq_done_irq));
  asc_analog_model analog (.i_core_clk(i_core_clk), .i_channel(o_conv_channel),
    .i_convert(o_conv_convert), .o_result(conv_result));

  initial begin
    forever #5 i_core_clk = ~i_core_clk;
  end
  // Channel order is recorded at the start of every sample phase
  always @(posedge i_core_clk) begin
    prev_sample <= o_conv_sample;
    if (o_conv_sample && !prev_sample) order.push_back(o_conv_channel);
  end

  function automatic logic [9:0] res(input logic [3:0] ch);
    return {ch, ~ch, 2'b10};
  endfunction

  task automatic acc(input logic wr, input logic [15:0] a, input logic wd, input logic [15:0] d);
    @(posedge i_core_clk); #1;
    i_bus_addr = a; i_bus_word = wd; i_bus_wdata = d; i_bus_rd = !wr; i_bus_wr = wr;
    @(posedge i_core_clk); #1;
    i_bus_rd = 1'b0; i_bus_wr = 1'b0; i_bus_addr = ~a; i_bus_wdata = ~d;
    q = o_bus_rdata; k = o_bus_ack;
  endtask
  task automatic wr(input logic [15:0] a, input logic wd, input logic [15:0] d);
    acc(1'b1, a, wd, d);
    `CHK("write ack", 1'b1, k)
  endtask
  task automatic rd(input string nm, input logic [15:0] a, input logic wd, input logic [15:0] ex);
    acc(1'b0, a, wd, 16'h0000);
    `CHK("read ack", 1'b1, k)
    `CHK(nm, ex, q)
  endtask
  task automatic wait_done(input int ch);
    for (n = 0; n < 400; n++) begin
      acc(1'b0, 16'h0284, 1'b1, 16'h0000);
      if (q[ch] === 1'b1) break;
    end
    if (n == 400) begin
      mismatches++;
      $display("[ERR] done flag wait expected 1 seen 0");
      summarize();
    end
  endtask
  task automatic summarize();
    $display("Counts: %0d compares, %0d mismatches", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge i_core_clk);
    #1 i_rst_b = 1'b1;
    rd("status reset", 16'h0281, 1'b0, 16'h000F);
    rd("done reset", 16'h0284, 1'b1, 16'h0000);
    acc(1'b0, 16'h02A6, 1'b0, 16'h0000);
    `CHK("unmapped ack", 1'b0, k)
    acc(1'b0, 16'h0180, 1'b0, 16'h0000);
    `CHK("other page ack", 1'b0, k)
    $display("Test reset and decode done");
    for (int c = 0; c < 7; c++) begin
      wr(16'h0280, 1'b0, 16'(c));
      repeat (12) @(posedge i_core_clk);
      n = 0;
      repeat (120) begin @(posedge i_core_clk); #1; if (o_converter_clock === 1'b1) n++; end
      `CHK("ticks in 120", (c < 5) ? 120 / (10 - 2 * c) : 120, n)
    end
    $display("Test divider done");
    wr(16'h0280, 1'b0, 16'h00AD);
    rd("config", 16'h0380, 1'b0, 16'h00A5);
    `CHK("offset comp out", 1'b1, o_offset_comp_en)
    i_ref_current_limit = 1'b1;
    wr(16'h0282, 1'b1, 16'h8001);
    wr(16'h0282, 1'b1, 16'h8400);
    wait_done(10);
    rd("flags after abort", 16'h0284, 1'b1, 16'h8400);
    `CHK("irq", 1'b1, o_seq_done_irq)
    rd("status done", 16'h0281, 1'b0, 16'h00CA);
    rd("status cleared", 16'h0381, 1'b0, 16'h004A);
    `CHK("irq cleared", 1'b0, o_seq_done_irq)
    wr(16'h0284, 1'b1, 16'h0000);
    rd("flags ro", 16'h0284, 1'b1, 16'h8400);
    rd("result ch10", 16'h029A, 1'b1, {res(4'd10), 6'h00});
    rd("flag cleared", 16'h0284, 1'b1, 16'h8000);
    $display("Test single channel done");
    i_ref_current_limit = 1'b0;
    wr(16'h0280, 1'b0, 16'h0005);
    order.delete();
    wr(16'h0283, 1'b0, 16'h0001);
    repeat (80) @(posedge i_core_clk);
    `CHK("low byte no start", 0, order.size())
    wr(16'h0282, 1'b0, 16'h0080);
    wait_done(0);
    `CHK("first channel", 4'hF, order[0])
    `CHK("second channel", 4'h0, order[1])
    rd("done lo byte", 16'h0285, 1'b0, 16'h0001);
    rd("done hi byte", 16'h0284, 1'b0, 16'h0080);
    rd("res lo", 16'h0287, 1'b0, {8'h00, 8'(res(4'd0) << 6)});
    rd("res hi", 16'h0286, 1'b0, {8'h00, 8'(res(4'd0) >> 2)});
    rd("done after hi", 16'h0285, 1'b0, 16'h0000);
    $display("Test byte access done");
    order.delete();
    wr(16'h0282, 1'b1, 16'hFFFF);
    rd("select bit 13", 16'h0282, 1'b1, 16'hDFFF);
    rd("flags cleared", 16'h0284, 1'b1, 16'h0000);
    wait_done(14);
    rd("all flags", 16'h0284, 1'b1, 16'hDFFF);
    `CHK("visit count", 15, order.size())
    `CHK("last channel", 4'hE, order[14])
    rd("result ch14", 16'h0386 + 16'd28, 1'b1, {res(4'd14), 6'h00});
    $display("Test full sequence done");
    wr(16'h0280, 1'b0, 16'h0045);
    wr(16'h0282, 1'b1, 16'h0002);
    wait_done(1);
    rd("result ch1", 16'h0288, 1'b1, {res(4'd1), 6'h00});
    wait_done(1);
    wr(16'h0282, 1'b1, 16'h0000);
    repeat (60) @(posedge i_core_clk);
    #1;
    `CHK("idle sample", 1'b0, o_conv_sample)
    `CHK("idle convert", 1'b0, o_conv_convert)
    $display("Test continuous and stop done");
    wr(16'h0280, 1'b0, 16'h0015);
    `CHK("soft reset out", 1'b1, o_converter_soft_reset)
    wr(16'h0282, 1'b1, 16'h0400);
    repeat (60) @(posedge i_core_clk);
    rd("status in reset", 16'h0281, 1'b0, 16'h000F);
    rd("flags in reset", 16'h0284, 1'b1, 16'h0000);
    wr(16'h0280, 1'b0, 16'h0005);
    rd("select after reset", 16'h0282, 1'b1, 16'h0000);
    $display("Test soft reset done");
    summarize();
  end
endmodule // asc_sequence_control_tb
